// ---- logic/abs_pkg.sv ----
// constants, types and register map for the alu and barrel shifter block
package abs_pkg;
	localparam int DW = 16;
	localparam int GW = 4;
	localparam int NG = 4;
	localparam int SW = 4;
	localparam int AW = 8;
	localparam int BYTE_GRP = 1;
	localparam int TOP_GRP = 3;

	localparam logic [AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [AW-1:0] OFS_SHAMT = 8'h04;
	localparam logic [AW-1:0] OFS_XOP = 8'h08;
	localparam logic [AW-1:0] OFS_YOP = 8'h0c;
	localparam logic [AW-1:0] OFS_RESULT = 8'h10;
	localparam logic [AW-1:0] OFS_ADDER = 8'h14;
	localparam logic [AW-1:0] OFS_STATUS = 8'h18;

	localparam int CTRL_FUNC_LSB = 0;
	localparam int CTRL_BLK_BIT = 4;
	localparam int CTRL_SHSEL_LSB = 5;
	localparam int ST_OVF_BIT = 0;
	localparam int ST_CARRYN_LSB = 1;
	localparam int ST_MSB_BIT = 5;
	localparam int ST_LSB_BIT = 6;
	localparam int ST_ARITH_BIT = 7;
	localparam int ST_LEFT_BIT = 8;
	localparam int ST_RIGHT_BIT = 9;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [DW-1:0] DATA_RST = 16'h0000;
	localparam logic [SW-1:0] SHAMT_RST = 4'h0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		SH_NONE = 2'b00,
		SH_RIGHT = 2'b01,
		SH_LEFT = 2'b10,
		SH_CIRC = 2'b11
	} abs_shift_t;

	typedef enum logic [3:0] {
		FN_ADD = 4'b0000, FN_NOR = 4'b0001, FN_NXAY = 4'b0010,
		FN_ADD1 = 4'b0011, FN_NAND = 4'b0100, FN_ORADD = 4'b0101,
		FN_XOR = 4'b0110, FN_XANY = 4'b0111, FN_NXOY = 4'b1000,
		FN_EQV = 4'b1001, FN_ANDADD = 4'b1010, FN_AND = 4'b1011,
		FN_SUB1 = 4'b1100, FN_XONY = 4'b1101, FN_OR = 4'b1110,
		FN_SUB = 4'b1111
	} abs_func_t;
endpackage

// ---- logic/abs_alu_shifter.sv ----
// alu with byte carry block and two-level barrel shifter, axi4-lite slave
`timescale 1ns/1ps
module abs_alu_shifter import abs_pkg::*; (
	input wire logic aclk, // 25 MHz clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [AW-1:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write byte enables
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [AW-1:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic [DW-1:0] shifter_out, // captured shifter output
	output logic [DW-1:0] adder_out, // captured adder result
	output logic adder_overflow, // captured top group carry
	output logic [NG-1:0] group_carry_n, // complemented group carries
	output logic adder_msb, // captured adder msb
	output logic adder_lsb // captured adder lsb
);
	// one-hot of a two-line select, gated by its strobe
	function automatic logic [3:0] dec4(input logic [1:0] sel,
			input logic strobe);
		dec4 = strobe ? 4'(4'h1 << sel) : 4'h0;
	endfunction

	function automatic logic [DW-1:0] rotr(input logic [DW-1:0] d,
			input logic [SW-1:0] n);
		logic [2*DW-1:0] t;
		t = {d, d} >> n;
		rotr = t[DW-1:0];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[8*i +: 8] = nw[8*i +: 8];
			end
		end
	endfunction

	function automatic logic [DW-1:0] logic_op(input abs_func_t f,
			input logic [DW-1:0] x, input logic [DW-1:0] y);
		case (f)
			FN_NOR: logic_op = ~(x | y);
			FN_NXAY: logic_op = ~x & y;
			FN_NAND: logic_op = ~(x & y);
			FN_XOR: logic_op = x ^ y;
			FN_XANY: logic_op = x & ~y;
			FN_NXOY: logic_op = ~x | y;
			FN_EQV: logic_op = ~(x ^ y);
			FN_AND: logic_op = x & y;
			FN_XONY: logic_op = x | ~y;
			FN_OR: logic_op = x | y;
			default: logic_op = DATA_RST;
		endcase
	endfunction

	abs_func_t func_q, func_d;
	logic microword_bit_27_q, microword_bit_27_d;
	abs_shift_t shsel_q, shsel_d;
	logic [SW-1:0] shamt_q, shamt_d;
	logic [DW-1:0] x_q, x_d, y_q, y_d;
	logic [AW-1:0] awaddr_q, awaddr_d;
	logic aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, arready_q, arready_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [DW-1:0] shifter_out_q, shifter_out_d, adder_out_q, adder_out_d;
	logic adder_overflow_q, adder_overflow_d;
	logic [NG-1:0] group_carry_n_q, group_carry_n_d;
	logic adder_msb_q, adder_msb_d, adder_lsb_q, adder_lsb_d;

	logic arith_select, lsb_carry_in, byte_carry_block_n;
	logic [DW-1:0] opnd_b, sum, adder_result;
	logic [NG:0] gcin;
	logic [NG-1:0] gco, grp_carry;
	logic top_group_carry, low_byte_carry;
	logic left_enable, right_enable, strobe_r, strobe_l;
	logic [SW-1:0] eff_amt;
	logic shift_amount_line_1, shift_amount_line_2;
	logic shift_amount_line_3, shift_amount_line_6;
	logic [3:0] true_l1, comp_l1, true_l2, comp_l2;
	logic [2:0] en1, en2_top;
	logic [3:0] en2_low;
	logic [DW-1:0] mask1, mask2, rot1, rot2, first_level_out, barrel_shifter;

	// arithmetic codes; every other code is a logic function
	always_comb begin
		arith_select = 1'b0;
		lsb_carry_in = 1'b0;
		opnd_b = y_q;
		case (func_q)
			FN_ADD: arith_select = 1'b1;
			FN_ADD1: begin
				arith_select = 1'b1;
				lsb_carry_in = 1'b1;
			end
			FN_ORADD: begin
				arith_select = 1'b1;
				opnd_b = x_q | y_q;
			end
			FN_ANDADD: begin
				arith_select = 1'b1;
				opnd_b = x_q & y_q;
			end
			FN_SUB1: begin
				arith_select = 1'b1;
				opnd_b = ~y_q;
			end
			FN_SUB: begin
				arith_select = 1'b1;
				opnd_b = ~y_q;
				lsb_carry_in = 1'b1;
			end
			default: arith_select = 1'b0;
		endcase
	end

	assign byte_carry_block_n = ~microword_bit_27_q;
	assign gcin[0] = lsb_carry_in;

	genvar g;
	generate
		for (g = 0; g < NG; g++) begin : g_grp
			logic [GW:0] gs;
			assign gs = {1'b0, x_q[g*GW +: GW]} + {1'b0, opnd_b[g*GW +: GW]}
				+ {{GW{1'b0}}, gcin[g]};
			assign sum[g*GW +: GW] = gs[GW-1:0];
			assign gco[g] = gs[GW];
			if (g == BYTE_GRP) begin : g_blk
				assign gcin[g+1] = gco[g] & byte_carry_block_n;
			end else begin : g_pass
				assign gcin[g+1] = gco[g];
			end
		end
	endgenerate

	// carries mean nothing in logic mode, so they read as zero there
	assign grp_carry = arith_select ? gco : 4'h0;
	assign low_byte_carry = grp_carry[BYTE_GRP];
	assign top_group_carry = grp_carry[TOP_GRP];
	assign adder_result = arith_select ? sum
		: logic_op(func_q, x_q, y_q);

	assign left_enable = (shsel_q == SH_LEFT) || (shsel_q == SH_CIRC);
	assign right_enable = (shsel_q != SH_LEFT);
	assign eff_amt = (shsel_q == SH_NONE) ? SHAMT_RST : shamt_q;
	assign shift_amount_line_1 = eff_amt[3];
	assign shift_amount_line_2 = eff_amt[2];
	assign shift_amount_line_3 = eff_amt[1];
	assign shift_amount_line_6 = eff_amt[0];
	assign strobe_r = right_enable & ~left_enable;
	// left by zero must pass, so the left strobe needs a nonzero amount
	assign strobe_l = left_enable & ~right_enable & (|eff_amt);
	assign true_l1 = dec4({shift_amount_line_1, shift_amount_line_2},
		strobe_r);
	assign comp_l1 = dec4({shift_amount_line_1, shift_amount_line_2},
		strobe_l);
	assign true_l2 = dec4({shift_amount_line_3, shift_amount_line_6},
		strobe_r);
	assign comp_l2 = dec4({shift_amount_line_3, shift_amount_line_6},
		strobe_l);

	assign rot1 = rotr(adder_result, {shift_amount_line_1,
		shift_amount_line_2, 2'b00});
	generate
		for (g = 0; g < 3; g++) begin : g_en
			localparam logic [3:0] LO = 4'((1 << (g + 1)) - 1);
			localparam logic [3:0] LO_R = 4'((1 << (4 - g)) - 1);
			assign en1[g] = (|(true_l1 & ~LO)) | (|(comp_l1 & LO));
			assign mask1[DW-1-GW*g -: GW] = {GW{en1[g]}};
			assign en2_top[g] = |(true_l2 & ~LO);
			assign mask2[DW-1-g] = en2_top[g];
			assign en2_low[g] = |(comp_l2 & LO_R);
			assign mask2[g] = en2_low[g];
		end
	endgenerate
	assign en2_low[3] = |(comp_l2 & 4'h1);
	assign mask2[3] = en2_low[3];
	assign mask2[DW-4:4] = '0;
	assign mask1[GW-1:0] = '0;
	assign first_level_out = rot1 & ~mask1;
	assign rot2 = rotr(first_level_out, {2'b00, shift_amount_line_3,
		shift_amount_line_6});
	assign barrel_shifter = rot2 & ~mask2;

	// destination registers capture the combinational datapath
	always_comb begin
		shifter_out_d = barrel_shifter;
		adder_out_d = adder_result;
		adder_overflow_d = top_group_carry;
		group_carry_n_d = ~grp_carry;
		adder_msb_d = adder_result[DW-1];
		adder_lsb_d = adder_result[0];
	end

	always_comb begin
		logic [31:0] cur;
		cur = WORD_ZERO;
		func_d = func_q;
		microword_bit_27_d = microword_bit_27_q;
		shsel_d = shsel_q;
		shamt_d = shamt_q;
		x_d = x_q;
		y_d = y_q;
		awaddr_d = awaddr_q;
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (awvalid && awready_q) begin
			aw_held_d = 1'b1;
			awaddr_d = awaddr;
		end
		if (wvalid && wready_q) begin
			w_held_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		if (aw_held_q && w_held_q && !bvalid_q) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			case (awaddr_q)
				OFS_CTRL: begin
					cur = WORD_ZERO;
					cur[CTRL_FUNC_LSB +: 4] = func_q;
					cur[CTRL_BLK_BIT] = microword_bit_27_q;
					cur[CTRL_SHSEL_LSB +: 2] = shsel_q;
					cur = merge(cur, wdata_q, wstrb_q);
					func_d = abs_func_t'(cur[CTRL_FUNC_LSB +: 4]);
					microword_bit_27_d = cur[CTRL_BLK_BIT];
					shsel_d = abs_shift_t'(cur[CTRL_SHSEL_LSB +: 2]);
				end
				OFS_SHAMT: begin
					cur = merge({28'h0, shamt_q}, wdata_q, wstrb_q);
					shamt_d = cur[SW-1:0];
				end
				OFS_XOP: begin
					cur = merge({16'h0, x_q}, wdata_q, wstrb_q);
					x_d = cur[DW-1:0];
				end
				OFS_YOP: begin
					cur = merge({16'h0, y_q}, wdata_q, wstrb_q);
					y_d = cur[DW-1:0];
				end
				OFS_RESULT, OFS_ADDER, OFS_STATUS: bresp_d = RESP_OKAY;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
		if (arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = WORD_ZERO;
			case (araddr)
				OFS_CTRL: begin
					rdata_d[CTRL_FUNC_LSB +: 4] = func_q;
					rdata_d[CTRL_BLK_BIT] = microword_bit_27_q;
					rdata_d[CTRL_SHSEL_LSB +: 2] = shsel_q;
				end
				OFS_SHAMT: rdata_d[SW-1:0] = shamt_q;
				OFS_XOP: rdata_d[DW-1:0] = x_q;
				OFS_YOP: rdata_d[DW-1:0] = y_q;
				OFS_RESULT: rdata_d[DW-1:0] = shifter_out_q;
				OFS_ADDER: rdata_d[DW-1:0] = adder_out_q;
				OFS_STATUS: begin
					rdata_d[ST_OVF_BIT] = adder_overflow_q;
					rdata_d[ST_CARRYN_LSB +: NG] = group_carry_n_q;
					rdata_d[ST_MSB_BIT] = adder_msb_q;
					rdata_d[ST_LSB_BIT] = adder_lsb_q;
					rdata_d[ST_ARITH_BIT] = arith_select;
					rdata_d[ST_LEFT_BIT] = left_enable;
					rdata_d[ST_RIGHT_BIT] = right_enable;
				end
				default: rresp_d = RESP_SLVERR;
			endcase
		end
		awready_d = !aw_held_d && !bvalid_d;
		wready_d = !w_held_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			func_q <= FN_ADD;
			microword_bit_27_q <= 1'b0;
			shsel_q <= SH_NONE;
			shamt_q <= SHAMT_RST;
			x_q <= DATA_RST;
			y_q <= DATA_RST;
			awaddr_q <= '0;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			wdata_q <= WORD_ZERO;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			arready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= WORD_ZERO;
			shifter_out_q <= DATA_RST;
			adder_out_q <= DATA_RST;
			adder_overflow_q <= 1'b0;
			group_carry_n_q <= 4'hf;
			adder_msb_q <= 1'b0;
			adder_lsb_q <= 1'b0;
		end else begin
			func_q <= func_d;
			microword_bit_27_q <= microword_bit_27_d;
			shsel_q <= shsel_d;
			shamt_q <= shamt_d;
			x_q <= x_d;
			y_q <= y_d;
			awaddr_q <= awaddr_d;
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			shifter_out_q <= shifter_out_d;
			adder_out_q <= adder_out_d;
			adder_overflow_q <= adder_overflow_d;
			group_carry_n_q <= group_carry_n_d;
			adder_msb_q <= adder_msb_d;
			adder_lsb_q <= adder_lsb_d;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign arready = arready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;
	assign shifter_out = shifter_out_q;
	assign adder_out = adder_out_q;
	assign adder_overflow = adder_overflow_q;
	assign group_carry_n = group_carry_n_q;
	assign adder_msb = adder_msb_q;
	assign adder_lsb = adder_lsb_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_pair;
		aw_held_q && w_held_q && !bvalid_q;
	endsequence
	sequence rd_taken;
		arvalid && arready_q;
	endsequence

	a_logic_path: assert property (func_q == FN_XOR |->
		!arith_select && adder_result == (x_q ^ y_q))
		else $error("logic mode does not use logic result");
	a_add_plain: assert property (func_q == FN_ADD &&
		!microword_bit_27_q |-> adder_result == 16'(x_q + y_q))
		else $error("add result wrong");
	a_nor_func: assert property (func_q == FN_NOR |->
		adder_result == ~(x_q | y_q))
		else $error("nor result wrong");
	a_sub_carry: assert property (func_q == FN_SUB &&
		!microword_bit_27_q |-> adder_result == 16'(x_q - y_q))
		else $error("subtract result wrong");
	a_byte_block: assert property (func_q == FN_ADD &&
		microword_bit_27_q |-> adder_result ==
		{8'(x_q[15:8] + y_q[15:8]), 8'(x_q[7:0] + y_q[7:0])})
		else $error("byte carry not blocked");
	a_overflow_out: assert property (##1 adder_overflow_q ==
		$past(arith_select && gco[TOP_GRP]))
		else $error("overflow not captured from top carry");
	a_carry_comp: assert property (func_q == FN_ADD |=>
		group_carry_n_q[0] == !$past(5'({1'b0, x_q[GW-1:0]}
		+ {1'b0, y_q[GW-1:0]}) > 5'h0f))
		else $error("complemented carries wrong");
	a_right_endoff: assert property (shsel_q == SH_RIGHT |=>
		shifter_out_q == $past(adder_result >> shamt_q))
		else $error("right end-off shift wrong");
	a_circ_rotate: assert property (shsel_q == SH_CIRC |=>
		shifter_out_q == $past(16'({adder_result, adder_result}
		>> shamt_q)))
		else $error("circular shift wrong");
	a_left_endoff: assert property (shsel_q == SH_LEFT &&
		shamt_q != 4'h0 |=> shifter_out_q == $past(16'(adder_result
		<< (5'h10 - {1'b0, shamt_q}))))
		else $error("left end-off shift wrong");
	a_no_shift: assert property (shsel_q == SH_NONE |->
		first_level_out == adder_result && barrel_shifter == adder_result)
		else $error("no-shift does not pass adder result");
	a_write_resp: assert property (wr_pair |=> bvalid_q ##0 !aw_held_q)
		else $error("write not answered next cycle");
	a_read_answer: assert property (rd_taken |=> rvalid_q [*1] ##0
		!arready_q)
		else $error("read not answered next cycle");
endmodule

// ---- bench/abs_seq_model.sv ----
// axi4-lite master standing in for the microcode sequencer
`timescale 1ns/1ps
module abs_seq_model import abs_pkg::*; (
	input wire logic aclk, // bus clock
	output logic [AW-1:0] awaddr, // write address
	output logic awvalid, // write address valid
	input wire logic awready, // write address ready
	output logic [31:0] wdata, // write data
	output logic [3:0] wstrb, // write byte enables
	output logic wvalid, // write data valid
	input wire logic wready, // write data ready
	input wire logic [1:0] bresp, // write response
	input wire logic bvalid, // write response valid
	output logic bready, // write response ready
	output logic [AW-1:0] araddr, // read address
	output logic arvalid, // read address valid
	input wire logic arready, // read address ready
	input wire logic [31:0] rdata, // read data
	input wire logic [1:0] rresp, // read response
	input wire logic rvalid, // read data valid
	output logic rready // read data ready
);
	initial begin
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	// left shifts run as right shifts, so the count is complemented first
	function automatic logic [3:0] left_count(input int n);
		return 4'((16 - n) % 16);
	endfunction

	// released payload is inverted so a stale value is never mistaken
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d,
		output logic [1:0] r, input logic [3:0] s = 4'hf);
		logic aw_go;
		logic w_go;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_go = 1'b1;
		w_go = 1'b1;
		while (aw_go || w_go) begin
			@(posedge aclk);
			if (aw_go && awready) begin
				aw_go = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (w_go && wready) begin
				w_go = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		while (!bvalid) begin
			@(posedge aclk);
		end
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [AW-1:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (!arready) begin
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		araddr <= ~a;
		@(posedge aclk);
		while (!rvalid) begin
			@(posedge aclk);
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

// ---- bench/alu_and_barrel_shifter_test.sv ----
// self-checking bench for the alu and barrel shifter block
`timescale 1ns/1ps
module alu_and_barrel_shifter_test;
	import abs_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [AW-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb, group_carry_n;
	logic [1:0] bresp, rresp, resp;
	logic [DW-1:0] shifter_out, adder_out;
	logic adder_overflow, adder_msb, adder_lsb;
	int n_errors = 0;
	int checks = 0;
	int seed = 47;
	int ln;
	logic [15:0] cx, cy, e_sum, e_sft;
	logic [3:0] cf, cn;
	logic cb;
	logic [1:0] csh;
	logic [9:0] e_st;
	logic [15:0] dx [4] = '{16'h00ff, 16'h00ff, 16'hffff, 16'h0000};

	always #20 aclk = ~aclk;

	abs_alu_shifter uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .shifter_out(shifter_out), .adder_out(adder_out),
		.adder_overflow(adder_overflow), .group_carry_n(group_carry_n),
		.adder_msb(adder_msb), .adder_lsb(adder_lsb));

	abs_seq_model seq (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	task automatic chk(input string what, input logic [31:0] ev,
		input logic [31:0] gv);
		checks++;
		if (gv !== ev) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, ev, gv);
		end
	endtask

	task automatic chk_resp(input logic [1:0] ev, input logic [1:0] gv);
		checks++;
		if (gv !== ev) begin
			n_errors++;
			$display("unexpected response: expected %h seen %h", ev, gv);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// reference model, integer group by group
	task automatic calc();
		logic [15:0] a, b, r;
		logic [3:0] co;
		logic arith;
		int c, s, amt;
		a = (cf == FN_ORADD) ? (cx | cy) : cx;
		case (cf)
			FN_ORADD: b = cx;
			FN_ANDADD: b = cx & cy;
			FN_SUB1, FN_SUB: b = ~cy;
			default: b = cy;
		endcase
		c = (cf == FN_ADD1 || cf == FN_SUB) ? 1 : 0;
		arith = cf inside {FN_ADD, FN_ADD1, FN_ORADD, FN_ANDADD, FN_SUB1,
			FN_SUB};
		for (int g = 0; g < 4; g++) begin
			s = a[g*4 +: 4] + b[g*4 +: 4] + c;
			r[g*4 +: 4] = 4'(s);
			co[g] = (s > 15);
			c = (g == 1 && cb) ? 0 : s / 16;
		end
		case (cf)
			FN_NOR: r = ~(cx | cy);
			FN_NXAY: r = ~cx & cy;
			FN_NAND: r = ~(cx & cy);
			FN_XOR: r = cx ^ cy;
			FN_XANY: r = cx & ~cy;
			FN_NXOY: r = ~cx | cy;
			FN_EQV: r = ~(cx ^ cy);
			FN_AND: r = cx & cy;
			FN_XONY: r = cx | ~cy;
			FN_OR: r = cx | cy;
			default: ;
		endcase
		if (!arith)
			co = 4'h0;
		e_sum = r;
		amt = (csh == SH_NONE) ? 0 : int'(cn);
		case (csh)
			SH_RIGHT: e_sft = r >> amt;
			SH_LEFT: e_sft = r << ln;
			SH_CIRC: e_sft = 16'({r, r} >> amt);
			default: e_sft = r;
		endcase
		e_st = {csh != SH_LEFT, csh[1], arith, r[0], r[15], ~co, co[3]};
	endtask

	task automatic apply();
		seq.wr(OFS_CTRL, {25'h0, csh, cb, cf}, resp);
		chk_resp(RESP_OKAY, resp);
		seq.wr(OFS_SHAMT, {28'h0, cn}, resp);
		seq.wr(OFS_XOP, {16'h0, cx}, resp);
		seq.wr(OFS_YOP, {16'h0, cy}, resp);
		// outputs are captured one edge after the registers move
		repeat (2) @(posedge aclk);
		#1;
		calc();
		chk("adder", e_sum, adder_out);
		chk("shifter", e_sft, shifter_out);
		chk("overflow", e_st[0], adder_overflow);
		chk("carries", e_st[4:1], group_carry_n);
		chk("msb lsb", e_st[6:5], {adder_lsb, adder_msb});
		seq.rd(OFS_STATUS, rd, resp);
		chk("status", e_st, rd);
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		#1;
		chk("reset shifter", 32'h0, shifter_out);
		chk("reset carries", 32'hf, group_carry_n);
		for (int i = 0; i < 4; i++) begin
			seq.rd(8'(i * 4), rd, resp);
			chk("reset register", 32'h0, rd);
			chk_resp(RESP_OKAY, resp);
		end
		$display("test reset done");
		seq.rd(8'h1c, rd, resp);
		chk_resp(RESP_SLVERR, resp);
		chk("unmapped read", 32'h0, rd);
		seq.wr(8'h1c, 32'hffff_ffff, resp);
		chk_resp(RESP_SLVERR, resp);
		seq.wr(OFS_CTRL, 32'hffff_ffff, resp);
		seq.rd(OFS_CTRL, rd, resp);
		chk("control field", 32'h7f, rd);
		seq.wr(OFS_RESULT, 32'h0000_1234, resp);
		chk_resp(RESP_OKAY, resp);
		seq.rd(OFS_RESULT, rd, resp);
		cx = 16'h0;
		cy = 16'h0;
		cf = 4'hf;
		cb = 1'b1;
		csh = SH_CIRC;
		cn = 4'h0;
		calc();
		chk("read-only result", {16'h0, e_sft}, rd);
		// only byte one may change under a partial strobe
		seq.wr(OFS_XOP, 32'h0000_1234, resp);
		seq.wr(OFS_XOP, 32'hffff_ab00, resp, 4'h2);
		chk_resp(RESP_OKAY, resp);
		seq.rd(OFS_XOP, rd, resp);
		chk("byte strobe", 32'h0000_ab34, rd);
		$display("test bus done");
		for (int i = 0; i < 4; i++) begin
			cx = dx[i];
			cy = 16'h0001;
			cf = (i == 3) ? FN_SUB : FN_ADD;
			cb = (i == 1);
			csh = SH_NONE;
			cn = 4'hf;
			apply();
		end
		$display("test carry done");
		for (int f = 0; f < 16; f++) begin
			for (int h = 0; h < 4; h++) begin
				cf = 4'(f);
				csh = 2'(h);
				cx = 16'($random(seed));
				cy = 16'($random(seed));
				cb = 1'($random(seed));
				ln = (f * 4 + h) % 16;
				if (csh == SH_LEFT)
					cn = seq.left_count(ln);
				else
					cn = 4'($random(seed));
				apply();
			end
		end
		$display("test random done");
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		$display("unexpected timeout: expected finish seen hang");
		end_sim();
	end
endmodule
